// [docnd_cond_bit.sv]
// one output bit: inversion then override
`timescale 1ns/1ps
`default_nettype none
module docnd_cond_bit (
  input  wire logic srcBit,
  input  wire logic invBit,
  input  wire logic ovrSelBit,
  input  wire logic ovrLvlBit,
  output logic      pinBit
);
  always_comb begin
    // override wins over the inverted source
    pinBit = ovrSelBit ? ovrLvlBit : (srcBit ^ invBit);
  end
endmodule : docnd_cond_bit
`default_nettype wire

// [docnd_pkg.sv]
// constants of the digital output conditioning block
// How it works
// - a set bit in the polarity flip mask inverts the sense of the matching output when that output is not overridden.
// - a set bit in the override select mask drives that output from the override level mask.
// - for an overridden output a 0 level bit gives a low pin and a 1 gives a high pin.
// - the applied pin pattern entry always holds the exact bits driven on the outputs.
// - a routing table picks a source for each of five outputs from the output command object.
// - bits 0 to 15 of each entry serve the special functions, bits 16 to 31 the output levels.
package docnd_pkg;

  localparam int unsigned DATA_W = 32;

  // subindices of the output conditioning object
  localparam logic [7:0] COND_SUB_COUNT    = 8'h00;
  localparam logic [7:0] COND_SUB_UNUSED   = 8'h01;
  localparam logic [7:0] COND_SUB_POLFLIP  = 8'h02;
  localparam logic [7:0] COND_SUB_OVRSEL   = 8'h03;
  localparam logic [7:0] COND_SUB_OVRLVL   = 8'h04;
  localparam logic [7:0] COND_SUB_APPLIED  = 8'h05;
  localparam logic [7:0] COND_SUB_SPARE_A  = 8'h06;
  localparam logic [7:0] COND_SUB_SPARE_B  = 8'h07;
  localparam logic [7:0] COND_SUB_ROUTE_EN = 8'h08;

  // subindices of the output source mapping object
  localparam logic [7:0] ROUTE_SUB_COUNT = 8'h00;
  localparam logic [7:0] ROUTE_SUB_FIRST = 8'h01;

  // values after reset
  localparam logic [7:0]  COND_ENTRY_COUNT  = 8'h08;
  localparam logic [7:0]  ROUTE_ENTRY_COUNT = 8'h05;
  localparam logic [31:0] MASK_RESET        = 32'h0000_0000;
  localparam logic [15:0] SRC_SEL_RESET     = 16'h1080;

  // field layout of a conditioning entry
  localparam int unsigned SPECIAL_LSB = 0;
  localparam int unsigned SPECIAL_MSB = 15;
  localparam int unsigned LEVEL_LSB   = 16;
  localparam int unsigned LEVEL_MSB   = 31;

  // routing: count, and source select word layout
  localparam int unsigned ROUTE_COUNT   = 5;
  localparam int unsigned SRC_INV_BIT   = 7;
  localparam int unsigned SRC_IDX_MSB   = 6;
  localparam int unsigned ROUTE_EN_BIT  = 0;

endpackage : docnd_pkg

// [docnd_route_sel.sv]
// one routed output: picks a bit of the output command object
`timescale 1ns/1ps
`default_nettype none
module docnd_route_sel (
  input  wire logic [15:0]                 srcSel,
  input  wire logic [docnd_pkg::DATA_W-1:0] cmdWord,
  output logic                             routedBit
);
  import docnd_pkg::*;

  logic [SRC_IDX_MSB:0] idx;
  logic                 raw;

  always_comb begin
    idx = srcSel[SRC_IDX_MSB:0];
    raw = 1'b0;
    // index 0 is constant 0, 1..32 name command bits 0..31, larger ones read as 0
    if (idx != '0 && idx <= 7'(DATA_W)) begin
      raw = cmdWord[5'(idx - 7'd1)];
    end
    routedBit = raw ^ srcSel[SRC_INV_BIT];
  end
endmodule : docnd_route_sel
`default_nettype wire

// [docnd_top.sv]
// digital output conditioning: entry access, routing and pin drive
`timescale 1ns/1ps
`default_nettype none
module docnd_top #(
  parameter int unsigned NUM_ROUTES = docnd_pkg::ROUTE_COUNT
) (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic                         objWr,
  input  wire logic                         objRd,
  input  wire logic                         objMap,
  input  wire logic [7:0]                   objSub,
  input  wire logic [docnd_pkg::DATA_W-1:0] objWdata,
  input  wire logic [docnd_pkg::DATA_W-1:0] outCmd,
  output logic      [docnd_pkg::DATA_W-1:0] rdData_q,
  output logic                              ack_q,
  output logic                              err_q,
  output logic      [docnd_pkg::DATA_W-1:0] digOut_q
);
  import docnd_pkg::*;

  // routed outputs sit in the level half of the word
  if (NUM_ROUTES < 1 || NUM_ROUTES > (LEVEL_MSB - LEVEL_LSB + 1)) begin : g_chk
    $error("docnd_top: NUM_ROUTES out of range");
  end

  // conditioning entries
  logic [DATA_W-1:0] unusedMask_q;
  logic [DATA_W-1:0] unusedMask_d;
  logic [DATA_W-1:0] polFlip_q;
  logic [DATA_W-1:0] polFlip_d;
  logic [DATA_W-1:0] ovrSel_q;
  logic [DATA_W-1:0] ovrSel_d;
  logic [DATA_W-1:0] ovrLvl_q;
  logic [DATA_W-1:0] ovrLvl_d;
  logic [DATA_W-1:0] routeEn_q;
  logic [DATA_W-1:0] routeEn_d;

  // routing table
  logic [15:0] srcSel_q [NUM_ROUTES];
  logic [15:0] srcSel_d [NUM_ROUTES];

  // access answer
  logic [DATA_W-1:0] rdData_d;
  logic              ack_d;
  logic              err_d;

  // output path
  logic [DATA_W-1:0] srcVec;
  logic [DATA_W-1:0] pinVec;
  logic [NUM_ROUTES-1:0] routedBits;
  logic [DATA_W-1:0] digOut_d;

  // decode
  logic condHit;
  logic routeHit;
  logic [7:0] routeIdx;
  logic       routeValid;

  always_comb begin
    condHit    = ~objMap;
    routeHit   = objMap;
    routeIdx   = objSub - ROUTE_SUB_FIRST;
    routeValid = routeHit && (objSub >= ROUTE_SUB_FIRST)
                 && (objSub <= 8'(NUM_ROUTES));
  end

  // entry write path
  always_comb begin
    unusedMask_d = unusedMask_q;
    polFlip_d    = polFlip_q;
    ovrSel_d     = ovrSel_q;
    ovrLvl_d     = ovrLvl_q;
    routeEn_d    = routeEn_q;
    for (int i = 0; i < NUM_ROUTES; i++) begin
      srcSel_d[i] = srcSel_q[i];
    end
    if (objWr && condHit) begin
      unique case (objSub)
        COND_SUB_UNUSED:   unusedMask_d = objWdata;
        COND_SUB_POLFLIP:  polFlip_d    = objWdata;
        COND_SUB_OVRSEL:   ovrSel_d     = objWdata;
        COND_SUB_OVRLVL:   ovrLvl_d     = objWdata;
        COND_SUB_ROUTE_EN: routeEn_d    = objWdata;
        default: begin
        end
      endcase
    end
    if (objWr && routeValid) begin
      for (int i = 0; i < NUM_ROUTES; i++) begin
        if (routeIdx == 8'(i)) begin
          srcSel_d[i] = objWdata[15:0];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      unusedMask_q <= MASK_RESET;
      polFlip_q    <= MASK_RESET;
      ovrSel_q     <= MASK_RESET;
      ovrLvl_q     <= MASK_RESET;
      routeEn_q    <= MASK_RESET;
      for (int i = 0; i < NUM_ROUTES; i++) begin
        srcSel_q[i] <= SRC_SEL_RESET;
      end
    end else begin
      unusedMask_q <= unusedMask_d;
      polFlip_q    <= polFlip_d;
      ovrSel_q     <= ovrSel_d;
      ovrLvl_q     <= ovrLvl_d;
      routeEn_q    <= routeEn_d;
      for (int i = 0; i < NUM_ROUTES; i++) begin
        srcSel_q[i] <= srcSel_d[i];
      end
    end
  end

  // read path and refusal: counts are read only, spares read zero and drop writes
  always_comb begin
    rdData_d = rdData_q;
    ack_d    = objRd | objWr;
    err_d    = 1'b0;
    if (objRd) begin
      rdData_d = '0;
    end
    if (condHit) begin
      unique case (objSub)
        COND_SUB_COUNT: begin
          if (objRd) rdData_d = {24'h00_0000, COND_ENTRY_COUNT};
          err_d = objWr;
        end
        COND_SUB_UNUSED: begin
          if (objRd) rdData_d = unusedMask_q;
        end
        COND_SUB_POLFLIP: begin
          if (objRd) rdData_d = polFlip_q;
        end
        COND_SUB_OVRSEL: begin
          if (objRd) rdData_d = ovrSel_q;
        end
        COND_SUB_OVRLVL: begin
          if (objRd) rdData_d = ovrLvl_q;
        end
        COND_SUB_APPLIED: begin
          // the pattern is what the pins show, so a write cannot hold
          if (objRd) rdData_d = digOut_q;
        end
        COND_SUB_SPARE_A, COND_SUB_SPARE_B: begin
        end
        COND_SUB_ROUTE_EN: begin
          if (objRd) rdData_d = routeEn_q;
        end
        default: begin
          err_d = objRd | objWr;
        end
      endcase
    end else if (objSub == ROUTE_SUB_COUNT) begin
      if (objRd) rdData_d = {24'h00_0000, 8'(NUM_ROUTES)};
      err_d = objWr;
    end else if (routeValid) begin
      if (objRd) begin
        for (int i = 0; i < NUM_ROUTES; i++) begin
          if (routeIdx == 8'(i)) begin
            rdData_d = {16'h0000, srcSel_q[i]};
          end
        end
      end
    end else begin
      err_d = objRd | objWr;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdData_q <= MASK_RESET;
      ack_q    <= 1'b0;
      err_q    <= 1'b0;
    end else begin
      rdData_q <= rdData_d;
      ack_q    <= ack_d;
      err_q    <= err_d;
    end
  end

  // routed sources
  for (genvar r = 0; r < NUM_ROUTES; r++) begin : g_route
    docnd_route_sel u_route (
      .srcSel    (srcSel_q[r]),
      .cmdWord   (outCmd),
      .routedBit (routedBits[r])
    );
  end

  // direct command bits unless routing is on for the first level outputs
  always_comb begin
    srcVec = outCmd;
    if (routeEn_q[ROUTE_EN_BIT]) begin
      for (int r = 0; r < NUM_ROUTES; r++) begin
        srcVec[LEVEL_LSB + r] = routedBits[r];
      end
    end
  end

  for (genvar b = 0; b < DATA_W; b++) begin : g_bit
    docnd_cond_bit u_bit (
      .srcBit    (srcVec[b]),
      .invBit    (polFlip_q[b]),
      .ovrSelBit (ovrSel_q[b]),
      .ovrLvlBit (ovrLvl_q[b]),
      .pinBit    (pinVec[b])
    );
  end

  // one register stage: pins and the applied pattern are the same flops
  always_comb begin
    digOut_d = pinVec;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      digOut_q <= MASK_RESET;
    end else begin
      digOut_q <= digOut_d;
    end
  end

endmodule : docnd_top
`default_nettype wire

// [docnd_top_props.sv]
// checker for the digital output conditioning top
`timescale 1ns/1ps
`default_nettype none
module docnd_top_props #(
  parameter int unsigned NUM_ROUTES = 5
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        objWr,
  input wire logic        objRd,
  input wire logic        objMap,
  input wire logic [7:0]  objSub,
  input wire logic [31:0] objWdata,
  input wire logic [31:0] outCmd,
  input wire logic [31:0] rdData_q,
  input wire logic        ack_q,
  input wire logic        err_q,
  input wire logic [31:0] digOut_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic rdC;
  assign rdC = objRd && !objMap;
  a_ack_one_cycle: assert property (ack_q == $past(objWr || objRd))
    else $error("ack not a single cycle");
  a_err_with_ack: assert property (err_q |-> ack_q) else $error("err without ack");
  a_count_write_refused: assert property (objWr && objSub == 8'h00 |=> err_q)
    else $error("count write not refused");
  a_cond_count_read: assert property (rdC && objSub == 8'h00 |=> rdData_q == 32'h0000_0008)
    else $error("cond count wrong");
  a_applied_read_back: assert property (rdC && objSub == 8'h05 |=> rdData_q == $past(digOut_q))
    else $error("applied pattern read wrong");
  a_route_count_read: assert property (objRd && objMap && objSub == 8'h00 |=> rdData_q == NUM_ROUTES)
    else $error("route count wrong");
  a_spare_reads_zero: assert property (rdC && objSub == 8'h06 |=> rdData_q == 32'h0000_0000)
    else $error("spare entry not zero");
  c_write: cover property (objWr ##1 ack_q);
  c_refuse: cover property (err_q);
  c_applied: cover property (rdC && objSub == 8'h05);
endmodule : docnd_top_props
bind docnd_top docnd_top_props #(.NUM_ROUTES(NUM_ROUTES)) props (.*);
`default_nettype wire

// [test_docnd_top.sv]
// self-checking bench of the digital output conditioning top
`timescale 1ns/1ps
`default_nettype none
module test_docnd_top;
  import docnd_pkg::*;
  logic clk, nrst, objWr, objRd, objMap, e;
  logic [7:0] objSub;
  logic [31:0] objWdata, outCmd, rdData_q, digOut_q, q, pf, os, ol, re;
  logic ack_q, err_q;
  logic [15:0] sel [5];
  int error_cnt, comparisons;
  docnd_top dut (.clk(clk), .nrst(nrst), .objWr(objWr), .objRd(objRd), .objMap(objMap),
    .objSub(objSub), .objWdata(objWdata), .outCmd(outCmd), .rdData_q(rdData_q),
    .ack_q(ack_q), .err_q(err_q), .digOut_q(digOut_q));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task ck(input logic [31:0] a, input logic [31:0] b);
    comparisons++;
    if (a !== b) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, a, b);
    end
  endtask : ck
  // one access; ack and data sampled a cycle later as the bus promises
  task acc(input logic w, input logic m, input logic [7:0] s, input logic [31:0] d);
    objWr = w;
    objRd = !w;
    objMap = m;
    objSub = s;
    objWdata = d;
    @(posedge clk);
    #2 objWr = 0;
    objRd = 0;
    q = rdData_q;
    e = err_q;
    ck({31'h0, ack_q}, 32'h1);
    // idle edge: a strobe never rises in the step that lowered it
    @(posedge clk);
    #2 ck({30'h0, ack_q, err_q}, 32'h0);
  endtask : acc
  function automatic logic [31:0] expo(input logic [31:0] c);
    logic [31:0] s;
    logic [6:0] i;
    s = c;
    if (re[0]) for (int r = 0; r < 5; r++) begin
      i = sel[r][6:0];
      s[16+r] = ((i >= 1 && i <= 32) ? c[i-1] : 1'b0) ^ sel[r][7];
    end
    return (os & ol) | (~os & (s ^ pf));
  endfunction : expo
  initial begin
    {objWr, objRd, objMap, objSub, objWdata, outCmd} = '0;
    {pf, os, ol, re} = '0;
    foreach (sel[r]) sel[r] = SRC_SEL_RESET;
    nrst = 0;
    void'($urandom(32'h3c4f));
    repeat (4) @(posedge clk);
    #2 nrst = 1;
    // reset values and counts
    for (int s = 0; s < 9; s++) begin
      acc(0, 0, s[7:0], 0);
      ck(q, s == 0 ? 32'h0000_0008 : 32'h0000_0000);
      ck({31'h0, e}, 32'h0);
    end
    acc(0, 1, 8'h00, 0);
    ck(q, 32'h0000_0005);
    acc(0, 1, 8'h01, 0);
    ck(q, 32'h0000_1080);
    // refusals: count writes, unknown subindex
    acc(1, 0, 8'h00, 32'h0000_0003);
    ck({31'h0, e}, 32'h1);
    acc(1, 1, 8'h00, 32'h0000_0003);
    ck({31'h0, e}, 32'h1);
    acc(0, 0, 8'h09, 0);
    ck({31'h0, e}, 32'h1);
    acc(1, 1, 8'h06, 0);
    ck({31'h0, e}, 32'h1);
    // spare and applied entries drop writes without error
    acc(1, 0, 8'h06, 32'hffff_ffff);
    ck({31'h0, e}, 32'h0);
    acc(0, 0, 8'h06, 0);
    ck(q, 32'h0000_0000);
    acc(1, 0, 8'h05, 32'hffff_ffff);
    ck({31'h0, e}, 32'h0);
    acc(0, 0, 8'h05, 0);
    ck(q, 32'h0000_0000);
    for (int n = 0; n < 60; n++) begin
      pf = $urandom;
      os = n < 3 ? 32'h0 : $urandom; // early passes: inversion alone
      ol = $urandom;
      re = 32'(n[0]);
      acc(1, 0, 8'h02, pf);
      acc(1, 0, 8'h03, os);
      acc(1, 0, 8'h04, ol);
      acc(1, 0, 8'h08, re);
      for (int r = 0; r < 5; r++) begin
        sel[r] = {8'h00, 1'($urandom), 7'($urandom_range(0, 40))};
        acc(1, 1, 8'(r + 1), {16'h0, sel[r]});
      end
      acc(0, 0, 8'h02, 0);
      ck(q, pf);
      outCmd = $urandom;
      @(posedge clk);
      #2 ck(digOut_q, expo(outCmd));
      acc(0, 0, 8'h05, 0);
      ck(q, expo(outCmd));
    end
    // mid-run reset: entries and pins return to their reset values
    nrst = 0;
    @(posedge clk);
    #2 ck(digOut_q, 32'h0000_0000);
    nrst = 1;
    acc(0, 0, 8'h02, 0);
    ck(q, 32'h0000_0000);
    acc(0, 1, 8'h01, 0);
    ck(q, 32'h0000_1080);
    ck(digOut_q, outCmd);
    results();
  end
  task results();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
endmodule : test_docnd_top
`default_nettype wire
